// File: design/config_range_regs.vh
// register offsets, field positions, reset values and timing constants for the config block
`ifndef CONFIG_RANGE_REGS_VH
`define CONFIG_RANGE_REGS_VH
`define ADDR_SYSCFG 2'h0
`define ADDR_RANGE 2'h1
`define ADDR_EVCFG 2'h2
`define ADDR_STATUS 2'h3
`define SYSCFG_RESET 32'h0000_8000
`define SYSCFG_WMASK 32'h0000_FDFF
`define RANGE_RESET 32'h0000_0000
`define RANGE_RW_RESET 24'h15_0E12
`define EVCFG_RESET 32'h0000_0000
`define ZERO32 32'h0000_0000
`define BAUD_HI 15
`define BAUD_LO 13
`define ZC_INV_BIT 12
`define ZC_PULSE_BIT 11
`define ZC_DIS_BIT 10
`define SWIRE_BIT 8
`define TCOMP_BIT 7
`define HOLD_HI 6
`define HOLD_LO 5
`define PDN_HI 4
`define PDN_LO 3
`define REFDIS_BIT 2
`define PWM_BIT 1
`define ACC_BIT 0
`define EV_MC2_BIT 15
`define EV_MC1_BIT 14
`define EV_MAP1_LO 16
`define EV_MAP2_LO 20
`define EV_OT_MAP1_BIT 27
`define EV_OT_MAP2_BIT 28
`define NUM_EVENTS 5
`define CLK_HZ 40000000
`define ZC_PULSE_NS 100000
`define ZC_PULSE_CYC ((`ZC_PULSE_NS / 1000) * (`CLK_HZ / 1000000))
`define ZC_CNT_W 12
`define THERM_W 10
`define BAUD_1200 18'h0_04B0
`define BAUD_2400 18'h0_0960
`define BAUD_4800 18'h0_12C0
`define BAUD_9600 18'h0_2580
`define BAUD_19200 18'h0_4B00
`define BAUD_38400 18'h0_9600
`define BAUD_57600 18'h0_E100
`define BAUD_115200 18'h1_C200
`endif

// File: design/limit_compare.v
// one limit comparator producing an event level
`default_nettype none
module limit_compare #(
	parameter W = 32,
	parameter ABOVE = 1
) (
	input wire clk, // core clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable
	input wire sample, // computation cycle strobe
	input wire [W-1:0] measured, // measured output value
	input wire [W-1:0] limit, // programmed limit
	output reg passed // limit passed on last sample
);
	// compare on each computation cycle; sag passes below, others above
	always @(posedge clk) begin
		if (!rst_n) begin
			passed <= 1'b0;
		end else if (ce && sample) begin
			passed <= ABOVE ? (measured > limit) : (measured < limit);
		end
	end
endmodule
`default_nettype wire

// File: design/zero_cross_shaper.v
// zero-crossing output shaping: toggle or fixed pulse, invert and disable
`default_nettype none
`include "config_range_regs.vh"
module zero_cross_shaper (
	input wire clk, // core clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable
	input wire crossing, // one-cycle zero crossing strobe
	input wire pulseMode, // pulse instead of toggle
	input wire invert, // invert output polarity
	input wire pinDisable, // output pin disabled
	output reg zeroCrossOutput, // pin level
	output reg zeroCrossOe // pin output enable
);
	// pulse length in core cycles, cut to the counter width on purpose
	localparam [31:0] PULSE_LOAD = `ZC_PULSE_CYC;
	reg toggle_q;
	reg [`ZC_CNT_W-1:0] pulseCnt_q;
	wire rawLevel;
	// toggle state and pulse length counter
	always @(posedge clk) begin
		if (!rst_n) begin
			toggle_q <= 1'b0;
			pulseCnt_q <= {`ZC_CNT_W{1'b0}};
		end else if (ce) begin
			if (crossing) begin
				toggle_q <= ~toggle_q;
			end
			if (crossing && pulseMode) begin
				pulseCnt_q <= PULSE_LOAD[`ZC_CNT_W-1:0];
			end else if (pulseCnt_q != {`ZC_CNT_W{1'b0}}) begin
				pulseCnt_q <= pulseCnt_q - 1'b1;
			end
		end
	end
	assign rawLevel = pulseMode ? (pulseCnt_q != {`ZC_CNT_W{1'b0}}) : toggle_q;
	// registered pin drive
	always @(posedge clk) begin
		if (!rst_n) begin
			zeroCrossOutput <= 1'b0;
			zeroCrossOe <= 1'b0;
		end else if (ce) begin
			zeroCrossOutput <= pinDisable ? 1'b0 : (rawLevel ^ invert);
			zeroCrossOe <= ~pinDisable;
		end
	end
endmodule
`default_nettype wire

// File: design/config_range_event_logic.v
// configuration word, output scaling word, limits and event pins of the calculation engine
//
// Summary of operation
// - baud field codes 111..000 give 1200..115200 baud, reset 100 is 9600
// - baud change applies only at next power-up; host must save it
// - invert bit inverts zero-crossing output, reset clear
// - pulse mode gives 100 us pulses; otherwise output toggles per crossing
// - disable bit turns zero-crossing pin off, reset enabled
// - single-wire bit enables automatic transmission, reset off
// - thermal bit enables temperature compensation, reset off
// - hold field holds current, voltage, both or neither converter
// - power-down field shuts current, voltage, both or neither converter
// - reference bit set disables internal reference, reset enabled
// - accumulation bit runs accumulators; clear stops and zeroes them
// - unimplemented config bit reads zero, writes ignored
// - low three scaling word bytes are right-shift counts for outputs
// - power byte scales active and reactive power alike
// - each event pin unmapped, mapped to events, or manual
// - manual drive ignored while any event mapped to the pin
// - five limits compared against their measured outputs
// - overtemperature limit compared with 10-bit thermistor value
// - passed limit sets status flag and mapped event pins
// - held converter keeps running but its output reads zero
// - pin with active mapped event is driven high
`default_nettype none
`include "config_range_regs.vh"
module config_range_event_logic (
	input wire clk, // 40 MHz core clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable, freezes all state when low
	input wire powerUp, // one-cycle strobe at power-up, loads baud
	input wire computeTick, // one-cycle computation cycle strobe
	input wire regWrite, // register write strobe from command decoder
	input wire regRead, // register read strobe from command decoder
	input wire [1:0] regAddr, // register index
	input wire [31:0] regWdata, // write data
	output reg [31:0] regRdata, // registered read data
	output reg regRvalid, // read data valid pulse
	input wire zeroCrossing, // zero crossing strobe, same clock
	input wire [23:0] currentConverterIn, // current converter raw sample
	input wire [23:0] voltageConverterIn, // voltage converter raw sample
	input wire [31:0] voltageRms, // measured rms voltage
	input wire [31:0] currentRms, // measured rms current
	input wire [31:0] activePower, // measured active power
	input wire [31:0] reactivePower, // measured reactive power
	input wire [`THERM_W-1:0] thermistor, // 10-bit thermistor result
	input wire [31:0] sagLimit, // sag limit
	input wire [31:0] surgeLimit, // surge limit
	input wire [31:0] overCurrentLimit, // overcurrent limit
	input wire [31:0] overPowerLimit, // overpower limit
	input wire [`THERM_W-1:0] overTempLimit, // overtemperature limit
	input wire [7:0] energyShift, // derived energy shift count
	input wire [4:0] statusClear, // one-cycle clear per event flag
	output reg [17:0] baudRate, // active baud rate in baud
	output reg singleWireEnable, // automatic single-wire transmission
	output reg thermalCompEnable, // temperature compensation on
	output reg [1:0] converterPowerDown, // bit0 current, bit1 voltage off
	output reg internalRefDisable, // internal reference off
	output reg pulseOutputEnable, // pulse-width output on
	output reg accumulationEnable, // energy accumulators running
	output reg accumulatorClear, // level forcing accumulators to zero
	output reg [23:0] currentConverterOut, // current converter after hold
	output reg [23:0] voltageConverterOut, // voltage converter after hold
	output reg [31:0] voltageScaled, // rms voltage after shift
	output reg [31:0] currentScaled, // rms current after shift
	output reg [31:0] activeScaled, // active power after shift
	output reg [31:0] reactiveScaled, // reactive power after shift
	output reg [4:0] eventStatus, // sag, surge, overcurrent, overpower, overtemp
	output reg eventPin1, // event pin 1
	output reg eventPin2, // event pin 2
	output wire zeroCrossOutput, // zero crossing pin
	output wire zeroCrossOe // zero crossing pin output enable
);
	reg [31:0] sysCfg_q;
	reg [31:0] sysCfgAct_q;
	reg [23:0] range_q;
	reg [31:0] evCfg_q;
	reg [17:0] baud_d;
	wire [4:0] passed;
	wire [3:0] mapPin1;
	wire [3:0] mapPin2;
	wire anyMap1;
	wire anyMap2;

	// register writes; config bit 9 and config reserved bits are masked off, event word stored whole
	always @(posedge clk) begin
		if (!rst_n) begin
			sysCfg_q <= `SYSCFG_RESET;
			range_q <= `RANGE_RW_RESET;
			evCfg_q <= `EVCFG_RESET;
		end else if (ce && regWrite) begin
			case (regAddr)
				`ADDR_SYSCFG: sysCfg_q <= regWdata & `SYSCFG_WMASK;
				`ADDR_RANGE: range_q <= regWdata[23:0];
				`ADDR_EVCFG: evCfg_q <= regWdata;
				default: sysCfg_q <= sysCfg_q;
			endcase
		end
	end

	// register reads; top scaling byte comes from the device
	always @(posedge clk) begin
		if (!rst_n) begin
			regRdata <= `ZERO32;
			regRvalid <= 1'b0;
		end else if (ce) begin
			regRvalid <= regRead;
			if (regRead) begin
				case (regAddr)
					`ADDR_SYSCFG: regRdata <= sysCfg_q;
					`ADDR_RANGE: regRdata <= {energyShift, range_q};
					`ADDR_EVCFG: regRdata <= evCfg_q;
					`ADDR_STATUS: regRdata <= {27'h000_0000, eventStatus};
					default: regRdata <= `ZERO32;
				endcase
			end
		end
	end

	// settings copied into use on each computation cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			sysCfgAct_q <= `SYSCFG_RESET;
		end else if (ce && computeTick) begin
			sysCfgAct_q <= sysCfg_q;
		end
	end

	// baud decode, latched only at power-up
	always @* begin
		case (sysCfg_q[`BAUD_HI:`BAUD_LO])
			3'b111: baud_d = `BAUD_1200;
			3'b110: baud_d = `BAUD_2400;
			3'b101: baud_d = `BAUD_4800;
			3'b100: baud_d = `BAUD_9600;
			3'b011: baud_d = `BAUD_19200;
			3'b010: baud_d = `BAUD_38400;
			3'b001: baud_d = `BAUD_57600;
			default: baud_d = `BAUD_115200;
		endcase
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			baudRate <= `BAUD_9600;
		end else if (ce && powerUp) begin
			baudRate <= baud_d;
		end
	end

	// control outputs from the active configuration
	always @(posedge clk) begin
		if (!rst_n) begin
			singleWireEnable <= 1'b0;
			thermalCompEnable <= 1'b0;
			converterPowerDown <= 2'h0;
			internalRefDisable <= 1'b0;
			pulseOutputEnable <= 1'b0;
			accumulationEnable <= 1'b0;
			accumulatorClear <= 1'b1;
		end else if (ce) begin
			singleWireEnable <= sysCfgAct_q[`SWIRE_BIT];
			thermalCompEnable <= sysCfgAct_q[`TCOMP_BIT];
			converterPowerDown <= sysCfgAct_q[`PDN_HI:`PDN_LO];
			internalRefDisable <= sysCfgAct_q[`REFDIS_BIT];
			pulseOutputEnable <= sysCfgAct_q[`PWM_BIT];
			accumulationEnable <= sysCfgAct_q[`ACC_BIT];
			accumulatorClear <= ~sysCfgAct_q[`ACC_BIT];
		end
	end

	// converter hold: converter runs, its output is forced to zero
	always @(posedge clk) begin
		if (!rst_n) begin
			currentConverterOut <= 24'h00_0000;
			voltageConverterOut <= 24'h00_0000;
		end else if (ce) begin
			currentConverterOut <= sysCfgAct_q[`HOLD_LO] ? 24'h00_0000 : currentConverterIn;
			voltageConverterOut <= sysCfgAct_q[`HOLD_HI] ? 24'h00_0000 : voltageConverterIn;
		end
	end

	// output scaling by right shift
	always @(posedge clk) begin
		if (!rst_n) begin
			voltageScaled <= `ZERO32;
			currentScaled <= `ZERO32;
			activeScaled <= `ZERO32;
			reactiveScaled <= `ZERO32;
		end else if (ce) begin
			voltageScaled <= voltageRms >> range_q[7:0];
			currentScaled <= currentRms >> range_q[15:8];
			activeScaled <= $signed(activePower) >>> range_q[23:16];
			reactiveScaled <= $signed(reactivePower) >>> range_q[23:16];
		end
	end

	// limit comparators: sag, surge, overcurrent, overpower, overtemp
	// sag passes when the rms voltage falls below its limit
	limit_compare #(
		.W(32),
		.ABOVE(0)
	) cmpSag (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sample(computeTick),
		.measured(voltageRms),
		.limit(sagLimit),
		.passed(passed[0])
	);

	// surge passes when the rms voltage rises above its limit
	limit_compare #(
		.W(32),
		.ABOVE(1)
	) cmpSurge (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sample(computeTick),
		.measured(voltageRms),
		.limit(surgeLimit),
		.passed(passed[1])
	);

	// overcurrent watches the rms current
	limit_compare #(
		.W(32),
		.ABOVE(1)
	) cmpCur (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sample(computeTick),
		.measured(currentRms),
		.limit(overCurrentLimit),
		.passed(passed[2])
	);

	// overpower watches the active power
	limit_compare #(
		.W(32),
		.ABOVE(1)
	) cmpPow (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sample(computeTick),
		.measured(activePower),
		.limit(overPowerLimit),
		.passed(passed[3])
	);

	// overtemperature works on the narrow thermistor result only
	limit_compare #(
		.W(`THERM_W),
		.ABOVE(1)
	) cmpTemp (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sample(computeTick),
		.measured(thermistor),
		.limit(overTempLimit),
		.passed(passed[4])
	);

	// sticky status flags; set wins over clear
	always @(posedge clk) begin
		if (!rst_n) begin
			eventStatus <= 5'h00;
		end else if (ce) begin
			eventStatus <= (eventStatus & ~statusClear) | passed;
		end
	end

	// event pin mapping with manual fallback
	assign mapPin1 = evCfg_q[`EV_MAP1_LO+3:`EV_MAP1_LO];
	assign mapPin2 = evCfg_q[`EV_MAP2_LO+3:`EV_MAP2_LO];
	assign anyMap1 = (|mapPin1) | evCfg_q[`EV_OT_MAP1_BIT];
	assign anyMap2 = (|mapPin2) | evCfg_q[`EV_OT_MAP2_BIT];
	always @(posedge clk) begin
		if (!rst_n) begin
			eventPin1 <= 1'b0;
			eventPin2 <= 1'b0;
		end else if (ce) begin
			if (anyMap1) begin
				eventPin1 <= |({evCfg_q[`EV_OT_MAP1_BIT], mapPin1} & eventStatus);
			end else begin
				eventPin1 <= evCfg_q[`EV_MC1_BIT];
			end
			if (anyMap2) begin
				eventPin2 <= |({evCfg_q[`EV_OT_MAP2_BIT], mapPin2} & eventStatus);
			end else begin
				eventPin2 <= evCfg_q[`EV_MC2_BIT];
			end
		end
	end

	// zero crossing output shaping
	zero_cross_shaper zcShaper (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.crossing(zeroCrossing),
		.pulseMode(sysCfgAct_q[`ZC_PULSE_BIT]),
		.invert(sysCfgAct_q[`ZC_INV_BIT]),
		.pinDisable(sysCfgAct_q[`ZC_DIS_BIT]),
		.zeroCrossOutput(zeroCrossOutput),
		.zeroCrossOe(zeroCrossOe)
	);
endmodule
`default_nettype wire

// File: bench/config_range_checker_assertions.sv
// concurrent checks on the ports of the config, scaling and event block
`default_nettype none
module config_range_checker (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic ce, // enable
	input wire logic powerUp, // baud load
	input wire logic computeTick, // compute strobe
	input wire logic regRead, // read strobe
	input wire logic regRvalid, // read valid
	input wire logic [31:0] voltageRms, // rms voltage
	input wire logic [31:0] sagLimit, // sag limit
	input wire logic [4:0] statusClear, // flag clears
	input wire logic [31:0] activePower, // active power
	input wire logic [31:0] reactivePower, // reactive power
	input wire logic [17:0] baudRate, // baud
	input wire logic accumulationEnable, // accumulating
	input wire logic accumulatorClear, // zeroing
	input wire logic [31:0] activeScaled, // scaled active
	input wire logic [31:0] reactiveScaled, // scaled reactive
	input wire logic [4:0] eventStatus, // flags
	input wire logic zeroCrossOutput, // zc pin
	input wire logic zeroCrossOe // zc enable
);
	// one clock domain, checks quiet while reset is low
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (ce && regRead |=> regRvalid)
		else $error("read not answered");
	acc_zero_a: assert property (accumulatorClear == !accumulationEnable)
		else $error("accumulator clear not inverse of enable");
	zc_off_a: assert property (!zeroCrossOe |-> !zeroCrossOutput)
		else $error("disabled zero cross pin not low");
	baud_hold_a: assert property ($changed(baudRate) |-> $past(powerUp))
		else $error("baud changed without power-up");
	flag_sticky_a: assert property (
		($past(eventStatus) & ~eventStatus & ~$past(statusClear)) == 5'h00)
		else $error("event flag dropped without clear");
	flag_cause_a: assert property (|(eventStatus & ~$past(eventStatus)) |-> $past(computeTick)
		|| $past(computeTick, 2))
		else $error("event flag set without computation");
	sag_flag_a: assert property (ce && computeTick && voltageRms < sagLimit && !statusClear[0]
		|-> ##[1:2] eventStatus[0])
		else $error("sag flag not set");
	power_scale_a: assert property ($past(ce) && $past(activePower) == $past(reactivePower)
		|-> activeScaled == reactiveScaled)
		else $error("power outputs scaled differently");
	// main scenarios reached
	cover property (computeTick && eventStatus[0]);
	cover property (powerUp ##1 $changed(baudRate));
	cover property ($rose(zeroCrossOutput));
endmodule
bind config_range_event_logic config_range_checker u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
	.powerUp(powerUp), .computeTick(computeTick), .regRead(regRead), .regRvalid(regRvalid),
	.voltageRms(voltageRms), .sagLimit(sagLimit), .statusClear(statusClear),
	.activePower(activePower), .reactivePower(reactivePower), .baudRate(baudRate),
	.accumulationEnable(accumulationEnable), .accumulatorClear(accumulatorClear),
	.activeScaled(activeScaled), .reactiveScaled(reactiveScaled), .eventStatus(eventStatus),
	.zeroCrossOutput(zeroCrossOutput), .zeroCrossOe(zeroCrossOe));
`default_nettype wire

// File: bench/config_range_event_logic_tb_top.sv
// self-checking bench for the config, scaling and event block
`default_nettype none
module config_range_event_logic_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, ce = 1, powerUp = 0, computeTick = 0, regWrite = 0, regRead = 0;
	logic [1:0] regAddr = '0, converterPowerDown;
	logic [31:0] regWdata = '0, regRdata, voltageRms = 32'h0000_0100, currentRms = 32'h0000_0100;
	logic [31:0] activePower = 32'h0000_0100, reactivePower = 32'h0000_0100, sagLimit = '0;
	logic [31:0] surgeLimit = '1, overCurrentLimit = '1, overPowerLimit = '1;
	logic [23:0] currentConverterIn = 24'h00_1234, voltageConverterIn = 24'h00_5678;
	logic [23:0] currentConverterOut, voltageConverterOut;
	logic [9:0] thermistor = '0, overTempLimit = 10'h3FF;
	logic [7:0] energyShift = 8'h1B;
	logic [4:0] statusClear = '0, eventStatus;
	logic [17:0] baudRate;
	logic [17:0] bt [8] = '{18'h1_C200, 18'h0_E100, 18'h0_9600, 18'h0_4B00, 18'h0_2580,
		18'h0_12C0, 18'h0_0960, 18'h0_04B0};
	logic regRvalid, zeroCrossing = 0, singleWireEnable, thermalCompEnable, internalRefDisable;
	logic pulseOutputEnable, accumulationEnable, accumulatorClear, eventPin1, eventPin2;
	logic zeroCrossOutput, zeroCrossOe;
	logic [31:0] voltageScaled, currentScaled, activeScaled, reactiveScaled;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	config_range_event_logic u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .powerUp(powerUp),
		.computeTick(computeTick), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.zeroCrossing(zeroCrossing), .currentConverterIn(currentConverterIn),
		.voltageConverterIn(voltageConverterIn), .voltageRms(voltageRms),
		.currentRms(currentRms), .activePower(activePower), .reactivePower(reactivePower),
		.thermistor(thermistor), .sagLimit(sagLimit), .surgeLimit(surgeLimit),
		.overCurrentLimit(overCurrentLimit), .overPowerLimit(overPowerLimit),
		.overTempLimit(overTempLimit), .energyShift(energyShift), .statusClear(statusClear),
		.baudRate(baudRate), .singleWireEnable(singleWireEnable),
		.thermalCompEnable(thermalCompEnable), .converterPowerDown(converterPowerDown),
		.internalRefDisable(internalRefDisable), .pulseOutputEnable(pulseOutputEnable),
		.accumulationEnable(accumulationEnable), .accumulatorClear(accumulatorClear),
		.currentConverterOut(currentConverterOut), .voltageConverterOut(voltageConverterOut),
		.voltageScaled(voltageScaled), .currentScaled(currentScaled),
		.activeScaled(activeScaled), .reactiveScaled(reactiveScaled), .eventStatus(eventStatus),
		.eventPin1(eventPin1), .eventPin2(eventPin2), .zeroCrossOutput(zeroCrossOutput),
		.zeroCrossOe(zeroCrossOe));
	// 25 ns clock and a cycle ceiling against hangs
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one register write, one read with bounded wait for valid
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1;
		step(1);
		regWrite = 0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		int k;
		regAddr = a;
		regRead = 1;
		step(1);
		regRead = 0;
		for (k = 0; k < 4 && regRvalid !== 1'b1; k++) begin
			step(1);
		end
		chk(regRdata, exp);
		step(1);
	endtask
	task automatic tick(input int n);
		computeTick = 1;
		step(1);
		computeTick = 0;
		step(n);
	endtask
	task automatic pulse_in(ref logic s);
		s = 1;
		step(1);
		s = 0;
		step(2);
	endtask
	// reset values of both words and of the outputs
	task automatic t_reset();
		rd(0, 32'h0000_8000);
		rd(1, {energyShift, 24'h15_0E12});
		chk(baudRate, 18'h0_2580);
		chk({accumulationEnable, accumulatorClear, zeroCrossOe}, 3'b011);
	endtask
	// all bits set: loose bit dropped, controls follow at next tick, baud waits
	task automatic t_cfg();
		int c;
		wr(0, 32'hFFFF_FFFF);
		rd(0, 32'h0000_FDFF);
		chk(singleWireEnable, 0);
		tick(2);
		chk({singleWireEnable, thermalCompEnable, converterPowerDown, internalRefDisable,
			pulseOutputEnable, accumulationEnable, accumulatorClear}, 8'hFE);
		chk(currentConverterOut, 24'h00_0000);
		chk(voltageConverterOut, 24'h00_0000);
		chk({baudRate, zeroCrossOe}, {18'h0_2580, 1'b0});
		for (c = 0; c < 4; c++) begin
			currentConverterIn = 24'h00_1000 + c;
			voltageConverterIn = 24'h00_2000 + c;
			wr(0, (c << 3) | (c << 5));
			tick(2);
			chk(converterPowerDown, c);
			chk(currentConverterOut, c[0] ? 24'h0 : currentConverterIn);
			chk(voltageConverterOut, c[1] ? 24'h0 : voltageConverterIn);
		end
	endtask
	// every baud code, loaded only by the power-up strobe
	task automatic t_baud();
		int c;
		for (c = 0; c < 8; c++) begin
			wr(0, c << 13);
			pulse_in(powerUp);
			chk(baudRate, bt[c]);
		end
	endtask
	// shift counts per byte, top byte read-only
	task automatic t_scale();
		voltageRms = 32'h0000_0400;
		currentRms = 32'h0000_0400;
		activePower = 32'h0000_0400;
		reactivePower = 32'h0000_0400;
		energyShift = 8'h05;
		wr(1, 32'hFF03_0201); // small shifts, no overflow of 0x400 inputs
		rd(1, 32'h0503_0201);
		tick(2);
		chk(voltageScaled, 32'h0000_0200);
		chk(currentScaled, 32'h0000_0100);
		chk(activeScaled, 32'h0000_0080);
		chk(reactiveScaled, 32'h0000_0080);
		// enable low freezes the scaled output, high lets it follow again
		ce = 0;
		voltageRms = 32'h0000_0800;
		step(2);
		chk(voltageScaled, 32'h0000_0200);
		ce = 1;
		step(2);
		chk(voltageScaled, 32'h0000_0400);
		voltageRms = 32'h0000_0400;
	endtask
	// limits, sticky flags, mapped and manual pins
	task automatic t_event();
		tick(3);
		chk(eventStatus, 5'h00);
		thermistor = 10'h3FF;
		overTempLimit = 10'h3FE;
		tick(3);
		chk(eventStatus, 5'h10);
		wr(2, 32'h1000_C000);
		step(2);
		chk({eventPin1, eventPin2}, 2'b11);
		overTempLimit = 10'h3FF;
		tick(2);
		chk(eventStatus, 5'h10);
		statusClear = 5'h10;
		step(1);
		statusClear = 5'h00;
		step(2);
		chk({eventStatus, eventPin2}, 6'h00);
		sagLimit = 32'h0000_0401; // limit in the units of voltageRms
		wr(2, 32'h0001_0000);
		tick(3);
		chk({eventStatus, eventPin1, eventPin2}, 7'h06);
		surgeLimit = 32'h0000_03FF;
		overCurrentLimit = 32'h0000_03FF;
		overPowerLimit = 32'h0000_03FF;
		tick(3);
		chk(eventStatus, 5'h0F);
	endtask
	// toggle, then inverted pulse of 4000 cycles
	task automatic t_zc();
		logic z;
		wr(0, 32'h0);
		tick(2);
		z = zeroCrossOutput;
		pulse_in(zeroCrossing);
		chk(zeroCrossOutput, !z);
		wr(0, 32'h0000_1800);
		tick(4000);
		chk(zeroCrossOutput, 1);
		pulse_in(zeroCrossing);
		step(3998);
		chk(zeroCrossOutput, 0);
		step(1);
		chk(zeroCrossOutput, 1);
	endtask
	initial begin
		step(12);
		rst_n = 1;
		t_reset();
		t_cfg();
		t_baud();
		t_scale();
		t_event();
		t_zc();
		print_verdict();
	end
endmodule
`default_nettype wire
